// file: src/ssp_defines.vh
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// register indices carried in command byte bits 7:3
`define SSP_REG_CPU_CONTROL_REG 5'h10
`define SSP_REG_PIN_CONFIG_REG 5'h11
`define SSP_REG_GENERAL_IO_PINS 5'h14

// command byte fields
`define SSP_CMD_ADDR_HI 7
`define SSP_CMD_ADDR_LO 3
`define SSP_CMD_WRITE 1

// cpu_control_reg fields
`define SSP_CPU_IE 0
`define SSP_CPU_CONTROL_REG_RESET 8'h00

// pin_config_reg fields
`define SSP_PIN_MUXLO 0
`define SSP_PIN_MUXHI 1
`define SSP_PIN_ACTIVE_HIGH_IRQ 2
`define SSP_PIN_LEVEL 3
`define SSP_PIN_FDUP 4
`define SSP_PIN_CONFIG_REG_RESET 8'h00

// io_pin_reg fields
`define SSP_IO_OUT_HI 3
`define SSP_IO_OUT_LO 0
`define SSP_GENERAL_IO_PINS_RESET 4'h0

// timing
`define SSP_CLK_NS 10
`define SSP_IRQ_PULSE_NS 100
`define SSP_IRQ_PULSE_CYC ((`SSP_IRQ_PULSE_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_SOF_HIGH_NS 500000
`define SSP_SOF_HIGH_CYC (`SSP_SOF_HIGH_NS / `SSP_CLK_NS)
`define SSP_IDLE_J_BITS 32

`endif

// file: src/ssp_fifo.v
`timescale 1ns/1ps
module ssp_fifo #(
    parameter WIDTH = 13,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wrPtr_q;
    reg [AW:0] rdPtr_q;
    wire full;
    wire empty;

    assign empty = (wrPtr_q == rdPtr_q);
    assign full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    assign inReady = ~full;
    assign outValid = ~empty;
    assign outData = mem[rdPtr_q[AW-1:0]];

    always @(posedge sys_clk) begin
        if (inValid && !full) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= {(AW+1){1'b0}};
            rdPtr_q <= {(AW+1){1'b0}};
        end else begin
            if (inValid && !full) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (outReady && !empty) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule

// file: src/ssp_pin_logic.v
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_pin_logic #(
    parameter IRQ_W = 8,
    parameter SOF_HIGH_CYC = `SSP_SOF_HIGH_CYC,
    parameter FIFO_DEPTH = 8
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // serial port pins
    input wire sclk,
    input wire ssB,
    input wire mosiIn,
    output wire mosiOut,
    output wire mosiOe,
    output wire misoOut,
    output wire misoOe,
    // chip reset pin and request to rest of device
    input wire hardResetInB,
    output wire chipReset,
    // service request pin
    output wire irqOut,
    output wire irqOe,
    // general pins
    input wire [3:0] generalInputs,
    output wire [3:0] generalOutputs,
    output wire muxedStatusOut,
    // device-side events
    input wire [IRQ_W-1:0] irqFlags,
    input wire [7:0] statusBits,
    input wire busPowerPresentIn,
    input wire syncDetect,
    input wire busReset,
    input wire jState,
    input wire bitTick,
    input wire sofPulse,
    // other registers of the device, and the overrun flag
    output wire [4:0] extRdAddr,
    input wire [7:0] extRdData,
    output wire extWrValid,
    input wire extWrReady,
    output wire [4:0] extWrAddr,
    output wire [7:0] extWrData,
    output wire spiOverrun
);
    localparam [7:0] PULSE_CYC = `SSP_IRQ_PULSE_CYC;
    localparam [5:0] J_BITS = `SSP_IDLE_J_BITS;

    function isLocal;
        input [4:0] a;
        begin
            isLocal = (a == `SSP_REG_CPU_CONTROL_REG) || (a == `SSP_REG_PIN_CONFIG_REG) ||
                (a == `SSP_REG_GENERAL_IO_PINS);
        end
    endfunction

    // synchronisers
    reg sclkS1_q, sclkS2_q, sclkS3_q;
    reg ssS1_q, ssS2_q, activePrev_q;
    reg mosiS1_q, mosiS2_q;
    reg hrS1_q, hrS2_q;
    reg vbusS1_q, vbusS2_q;
    reg [3:0] gpinS1_q, gpinS2_q;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclkS1_q <= 1'b0;
            sclkS2_q <= 1'b0;
            sclkS3_q <= 1'b0;
            ssS1_q <= 1'b1;
            ssS2_q <= 1'b1;
            activePrev_q <= 1'b0;
            mosiS1_q <= 1'b0;
            mosiS2_q <= 1'b0;
            hrS1_q <= 1'b0;
            hrS2_q <= 1'b0;
            vbusS1_q <= 1'b0;
            vbusS2_q <= 1'b0;
            gpinS1_q <= 4'hF;
            gpinS2_q <= 4'hF;
        end else begin
            sclkS1_q <= sclk;
            sclkS2_q <= sclkS1_q;
            sclkS3_q <= sclkS2_q;
            ssS1_q <= ssB;
            ssS2_q <= ssS1_q;
            activePrev_q <= ~ssS2_q;
            mosiS1_q <= mosiIn;
            mosiS2_q <= mosiS1_q;
            hrS1_q <= hardResetInB;
            hrS2_q <= hrS1_q;
            vbusS1_q <= busPowerPresentIn;
            vbusS2_q <= vbusS1_q;
            gpinS1_q <= generalInputs;
            gpinS2_q <= gpinS1_q;
        end
    end

    wire active = ~ssS2_q;
    wire chipRst = ~hrS2_q;
    // both clock modes use the rising edge; SCLK ignored while deselected
    wire sRise = active & sclkS2_q & ~sclkS3_q;
    wire sFall = active & ~sclkS2_q & sclkS3_q;

    // device registers
    reg [7:0] pinCfg_q;
    reg [7:0] cpu_control_reg_q;
    reg [3:0] gpOut_q;
    wire fullDuplex = pinCfg_q[`SSP_PIN_FDUP];
    wire levelMode = pinCfg_q[`SSP_PIN_LEVEL];
    wire active_high_irq = pinCfg_q[`SSP_PIN_ACTIVE_HIGH_IRQ];
    wire irqEn = cpu_control_reg_q[`SSP_CPU_IE];

    // serial engine
    reg [2:0] bitCnt_q;
    reg [6:0] inSh_q;
    reg [7:0] cmd_q;
    reg cmdDone_q;
    reg gotRise_q;
    reg dataPhase_q;
    reg [7:0] outSh_q;
    reg pendValid_q;
    reg [12:0] pendData_q;
    reg overrun_q;
    reg misoOut_q, misoOe_q, mosiOut_q, mosiOe_q;

    wire [4:0] cmdAddr = cmd_q[`SSP_CMD_ADDR_HI:`SSP_CMD_ADDR_LO];
    wire cmdWrite = cmd_q[`SSP_CMD_WRITE];
    wire [7:0] rxByte = {inSh_q, mosiS2_q};
    wire byteEnd = sRise && (bitCnt_q == 3'd7);
    wire dataByte = byteEnd && cmdDone_q && cmdWrite;
    wire fifoInReady;
    reg [7:0] rdByte;

    always @* begin
        case (cmdAddr)
            `SSP_REG_CPU_CONTROL_REG: rdByte = cpu_control_reg_q;
            `SSP_REG_PIN_CONFIG_REG: rdByte = pinCfg_q;
            `SSP_REG_GENERAL_IO_PINS: rdByte = {gpinS2_q, gpOut_q};
            default: rdByte = extRdData;
        endcase
    end

    // serial logic has its own reset only: chip reset leaves it alone
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bitCnt_q <= 3'd0;
            inSh_q <= 7'h00;
            cmd_q <= 8'h00;
            cmdDone_q <= 1'b0;
            gotRise_q <= 1'b0;
            dataPhase_q <= 1'b0;
            outSh_q <= 8'h00;
        end else if (!active) begin
            // partial byte simply forgotten here
            bitCnt_q <= 3'd0;
            cmdDone_q <= 1'b0;
            gotRise_q <= 1'b0;
            dataPhase_q <= 1'b0;
        end else begin
            if (!activePrev_q) begin
                // first status bit ready before any clock edge
                outSh_q <= fullDuplex ? statusBits : 8'h00;
            end else if (sFall && gotRise_q) begin
                if (bitCnt_q == 3'd0) begin
                    dataPhase_q <= 1'b1;
                    outSh_q <= cmdWrite ? 8'h00 : rdByte;
                end else begin
                    outSh_q <= {outSh_q[6:0], 1'b0};
                end
            end
            if (sRise) begin
                gotRise_q <= 1'b1;
                bitCnt_q <= bitCnt_q + 3'd1;
                inSh_q <= rxByte[6:0];
                if (byteEnd && !cmdDone_q) begin
                    cmd_q <= rxByte;
                    cmdDone_q <= 1'b1;
                end
            end
        end
    end

    // byte handed to the fifo; held until taken unless the next byte overwrites it first, setting the overrun flag
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pendValid_q <= 1'b0;
            pendData_q <= 13'h0000;
            overrun_q <= 1'b0;
        end else begin
            // clear first so a loss in the same cycle still sets the flag
            if (active && !activePrev_q) begin
                overrun_q <= 1'b0;
            end
            if (dataByte) begin
                pendData_q <= {cmdAddr, rxByte};
                pendValid_q <= 1'b1;
                if (pendValid_q && !fifoInReady) begin
                    overrun_q <= 1'b1;
                end
            end else if (fifoInReady) begin
                pendValid_q <= 1'b0;
            end
        end
    end

    // pin drivers: MISO only in full duplex, MOSI turned round for reads
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            misoOut_q <= 1'b0;
            misoOe_q <= 1'b0;
            mosiOut_q <= 1'b0;
            mosiOe_q <= 1'b0;
        end else begin
            misoOut_q <= outSh_q[7];
            mosiOut_q <= outSh_q[7];
            misoOe_q <= active & fullDuplex;
            mosiOe_q <= active & ~fullDuplex & dataPhase_q & ~cmdWrite;
        end
    end

    // write path into device registers
    wire fifoOutValid;
    wire [12:0] fifoOutData;
    reg extWrValid_q;
    reg [4:0] extWrAddr_q;
    reg [7:0] extWrData_q;
    wire fifoOutReady = ~extWrValid_q;
    wire [4:0] wAddr = fifoOutData[12:8];
    wire [7:0] wData = fifoOutData[7:0];
    wire wTake = fifoOutValid & fifoOutReady;

    ssp_fifo #(
        .WIDTH(13),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .inValid(pendValid_q),
        .inReady(fifoInReady),
        .inData(pendData_q),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // pin config survives chip reset
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinCfg_q <= `SSP_PIN_CONFIG_REG_RESET;
        end else if (wTake && wAddr == `SSP_REG_PIN_CONFIG_REG) begin
            pinCfg_q <= wData;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_control_reg_q <= `SSP_CPU_CONTROL_REG_RESET;
            gpOut_q <= `SSP_GENERAL_IO_PINS_RESET;
            extWrValid_q <= 1'b0;
            extWrAddr_q <= 5'h00;
            extWrData_q <= 8'h00;
        end else if (chipRst) begin
            cpu_control_reg_q <= `SSP_CPU_CONTROL_REG_RESET;
            gpOut_q <= `SSP_GENERAL_IO_PINS_RESET;
            extWrValid_q <= 1'b0;
        end else begin
            if (extWrValid_q && extWrReady) begin
                extWrValid_q <= 1'b0;
            end
            if (wTake) begin
                if (wAddr == `SSP_REG_CPU_CONTROL_REG) begin
                    cpu_control_reg_q <= wData;
                end
                if (wAddr == `SSP_REG_GENERAL_IO_PINS) begin
                    gpOut_q <= wData[`SSP_IO_OUT_HI:`SSP_IO_OUT_LO];
                end
                if (!isLocal(wAddr)) begin
                    extWrValid_q <= 1'b1;
                    extWrAddr_q <= wAddr;
                    extWrData_q <= wData;
                end
            end
        end
    end

    // service request pin
    reg [IRQ_W-1:0] prevFlags_q;
    reg [7:0] pulseCnt_q;
    reg irqOut_q, irqOe_q;
    wire pending = |irqFlags;
    wire newReq = |(irqFlags & ~prevFlags_q);
    wire clrReq = (|(prevFlags_q & ~irqFlags)) & pending;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prevFlags_q <= {IRQ_W{1'b0}};
            pulseCnt_q <= 8'd0;
            irqOut_q <= 1'b0;
            irqOe_q <= 1'b0;
        end else begin
            prevFlags_q <= irqFlags;
            if (!irqEn || levelMode) begin
                pulseCnt_q <= 8'd0;
            end else if (newReq || clrReq) begin
                pulseCnt_q <= PULSE_CYC;
            end else if (pulseCnt_q != 8'd0) begin
                pulseCnt_q <= pulseCnt_q - 8'd1;
            end
            if (levelMode) begin
                // polarity bit not consulted here
                irqOut_q <= 1'b0;
                irqOe_q <= irqEn & pending & ~chipRst;
            end else begin
                irqOe_q <= 1'b1;
                irqOut_q <= active_high_irq ? (pulseCnt_q != 8'd0) : (pulseCnt_q == 8'd0);
            end
        end
    end

    // status indicators
    reg ready_q;
    reg traffic_indicator_q;
    reg [5:0] jCnt_q;
    reg sofWave_q;
    reg [31:0] sofCnt_q;
    reg gpx_q;
    reg chipRst_q;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_q <= 1'b0;
            chipRst_q <= 1'b1;
            traffic_indicator_q <= 1'b0;
            jCnt_q <= 6'd0;
            sofWave_q <= 1'b0;
            sofCnt_q <= 32'd0;
            gpx_q <= 1'b0;
        end else begin
            chipRst_q <= chipRst;
            ready_q <= ~chipRst;
            if (!jState || busReset || syncDetect) begin
                jCnt_q <= 6'd0;
            end else if (bitTick && jCnt_q != J_BITS) begin
                jCnt_q <= jCnt_q + 6'd1;
            end
            if (busReset || jCnt_q == J_BITS) begin
                traffic_indicator_q <= 1'b0;
            end else if (syncDetect) begin
                traffic_indicator_q <= 1'b1;
            end
            // high half a frame so the next frame start always makes an edge
            if (sofPulse) begin
                sofWave_q <= 1'b1;
                sofCnt_q <= SOF_HIGH_CYC;
            end else if (sofCnt_q != 32'd0) begin
                sofCnt_q <= sofCnt_q - 32'd1;
            end else begin
                sofWave_q <= 1'b0;
            end
            case ({pinCfg_q[`SSP_PIN_MUXHI], pinCfg_q[`SSP_PIN_MUXLO]})
                2'b00: gpx_q <= ready_q;
                2'b01: gpx_q <= vbusS2_q;
                2'b10: gpx_q <= traffic_indicator_q;
                default: gpx_q <= sofWave_q;
            endcase
        end
    end

    assign mosiOut = mosiOut_q;
    assign mosiOe = mosiOe_q;
    assign misoOut = misoOut_q;
    assign misoOe = misoOe_q;
    assign chipReset = chipRst_q;
    assign irqOut = irqOut_q;
    assign irqOe = irqOe_q;
    assign generalOutputs = gpOut_q;
    assign muxedStatusOut = gpx_q;
    assign extRdAddr = cmd_q[`SSP_CMD_ADDR_HI:`SSP_CMD_ADDR_LO];
    assign extWrValid = extWrValid_q;
    assign extWrAddr = extWrAddr_q;
    assign extWrData = extWrData_q;
    assign spiOverrun = overrun_q;
endmodule

// file: verification/ssp_pin_props_properties.sv
`timescale 1ns/1ps
module ssp_pin_props (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // watched ports
    input wire sclk,
    input wire ssB,
    input wire mosiOe,
    input wire misoOut,
    input wire misoOe,
    input wire chipReset,
    input wire irqOut,
    input wire [3:0] generalOutputs,
    input wire muxedStatusOut,
    input wire extWrValid,
    input wire extWrReady,
    input wire [4:0] extWrAddr,
    input wire [7:0] extWrData
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    chk_deselect_pins_off: assert property (ssB [*6] |-> !misoOe && !mosiOe)
        else $error("data pin driven while deselected");
    chk_one_data_driver: assert property (!(misoOe && mosiOe))
        else $error("both data pins driven");
    chk_miso_holds_high: assert property ((sclk && !ssB) [*8] |-> $stable(misoOut))
        else $error("miso moved while clock high");
    chk_irq_pulse_len: assert property ($changed(irqOut) |=> $stable(irqOut) [*8])
        else $error("service request pulse too short");
    chk_hard_reset_outs: assert property (chipReset |-> ##1 generalOutputs == 4'h0)
        else $error("general outputs kept through chip reset");
    chk_hard_reset_wr: assert property (chipReset ##1 chipReset |-> !extWrValid)
        else $error("register write offered in chip reset");
    chk_ready_after_reset: assert property ($fell(chipReset) |-> ##[1:3] muxedStatusOut)
        else $error("ready did not rise after chip reset");
    chk_write_holds: assert property (extWrValid && !extWrReady |=>
        extWrValid && $stable(extWrData) && $stable(extWrAddr))
        else $error("register write changed before taken");
endmodule

bind ssp_pin_logic ssp_pin_props ssp_pin_props_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .sclk(sclk), .ssB(ssB), .mosiOe(mosiOe), .misoOut(misoOut), .misoOe(misoOe),
    .chipReset(chipReset), .irqOut(irqOut), .generalOutputs(generalOutputs),
    .muxedStatusOut(muxedStatusOut), .extWrValid(extWrValid), .extWrReady(extWrReady),
    .extWrAddr(extWrAddr), .extWrData(extWrData));

// file: verification/ssp_spi_master.sv
`timescale 1ns/1ps
module ssp_spi_master (
    // link pins
    output logic sclk,
    output logic ssB,
    output wire mosiWire,
    // device data pins
    input wire logic mosiOut,
    input wire logic mosiOe,
    input wire logic misoOut,
    input wire logic misoOe
);
    logic drv = 1'b0;
    logic dat = 1'b1;
    logic cpol = 1'b0;
    logic lastLvl = 1'b1;
    initial sclk = 1'b0;
    initial ssB = 1'b1;
    // nobody drives and there is no pull: show the inverse of the last level
    assign mosiWire = mosiOe ? mosiOut : (drv ? dat : ~lastLvl);
    always @(mosiWire) if (mosiOe || drv) lastLvl = mosiWire;
    task automatic sel(input logic pol);
        cpol = pol;
        sclk = pol;
        #200;
        ssB = 1'b0;
        #80;
    endtask
    // msb first; a read is taken late in the high phase, where the bit still stands
    task automatic shift(input logic [7:0] tx, input int n, input logic own,
            input logic fd, output logic [7:0] rx);
        rx = 8'h00;
        drv = own;
        for (int i = 7; i > 7 - n; i--) begin
            sclk = 1'b0;
            dat = tx[i];
            #40;
            sclk = 1'b1;
            #40;
            rx[i] = fd ? misoOut : mosiWire;
        end
    endtask
    task automatic desel();
        if (!cpol) sclk = 1'b0;
        #40;
        drv = 1'b0;
        ssB = 1'b1;
        #200;
    endtask
endmodule

// file: verification/test_ssp_pin_logic.sv
`timescale 1ns/1ps
module test_ssp_pin_logic;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hardResetInB = 1'b1;
    logic [3:0] generalInputs = 4'hC;
    logic [7:0] irqFlags = 8'h00;
    logic [7:0] statusBits = 8'h96;
    logic busPowerPresentIn = 1'b0;
    logic syncDetect = 1'b0;
    logic busReset = 1'b0;
    logic jState = 1'b0;
    logic bitTick = 1'b0;
    logic sofPulse = 1'b0;
    logic extWrReady = 1'b0;
    logic fd = 1'b0;
    logic [7:0] st;
    logic [7:0] rx;
    logic [7:0] irqSeq [3] = '{8'h01, 8'h03, 8'h02};
    int badCount = 0;
    int nCompared = 0;
    wire sclk, ssB, mosiWire, mosiOut, mosiOe, misoOut, misoOe, chipReset, irqOut, irqOe;
    wire muxedStatusOut, extWrValid, spiOverrun;
    wire [3:0] generalOutputs;
    wire [4:0] extWrAddr, extRdAddr;
    wire [7:0] extWrData;
    always #5 sys_clk = ~sys_clk;
    ssp_pin_logic #(.SOF_HIGH_CYC(20)) ssp_pin_logic_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .sclk(sclk), .ssB(ssB), .mosiIn(mosiWire), .mosiOut(mosiOut), .mosiOe(mosiOe),
        .misoOut(misoOut), .misoOe(misoOe), .hardResetInB(hardResetInB),
        .chipReset(chipReset), .irqOut(irqOut), .irqOe(irqOe), .generalInputs(generalInputs),
        .generalOutputs(generalOutputs), .muxedStatusOut(muxedStatusOut),
        .irqFlags(irqFlags), .statusBits(statusBits), .busPowerPresentIn(busPowerPresentIn),
        .syncDetect(syncDetect), .busReset(busReset), .jState(jState), .bitTick(bitTick),
        .sofPulse(sofPulse), .extRdAddr(extRdAddr), .extRdData(8'h00),
        .extWrValid(extWrValid),
        .extWrReady(extWrReady), .extWrAddr(extWrAddr), .extWrData(extWrData),
        .spiOverrun(spiOverrun));
    ssp_spi_master ssp_spi_master_i (.sclk(sclk), .ssB(ssB), .mosiWire(mosiWire),
        .mosiOut(mosiOut), .mosiOe(mosiOe), .misoOut(misoOut), .misoOe(misoOe));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // one access: command, then n data bytes, the last one nb bits long
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [7:0] d,
            input logic md, input int nb);
        cyc(1);
        #3;
        ssp_spi_master_i.sel(md);
        ssp_spi_master_i.shift(cmd, 8, 1'b1, fd, st);
        for (int i = 0; i < n; i++)
            ssp_spi_master_i.shift(d + i[7:0], (i == n - 1) ? nb : 8, cmd[1] | fd, fd, rx);
        ssp_spi_master_i.desel();
        // back onto the falling edge for whatever the caller drives next
        cyc(1);
    endtask
    task automatic mux(input string what, input logic e);
        cyc(4);
        chk(what, {7'h0, e}, {7'h0, muxedStatusOut});
    endtask
    task automatic t_half();
        chk("irq idle", 8'h01, {7'h0, irqOut});
        chk("gpout reset", 8'h00, {4'h0, generalOutputs});
        xfer(8'hA2, 1, 8'hA5, 1'b0, 8);
        chk("gpout", 8'h05, {4'h0, generalOutputs});
        xfer(8'hA0, 1, 8'h00, 1'b0, 8);
        chk("half read", 8'hC5, rx);
        xfer(8'hA2, 1, 8'h0A, 1'b0, 7);
        chk("partial", 8'h05, {4'h0, generalOutputs});
        $display("half duplex test done");
    endtask
    task automatic t_full();
        xfer(8'h8A, 1, 8'h10, 1'b0, 8);
        fd = 1'b1;
        for (int md = 0; md < 2; md++) begin
            xfer(8'hA0, 1, 8'hFF, md[0], 8);
            chk("status", 8'h96, st);
            chk("full read", 8'hC5, rx);
        end
        xfer(8'hA2, 1, 8'h03, 1'b1, 8);
        chk("write miso", 8'h00, rx);
        chk("gpout", 8'h03, {4'h0, generalOutputs});
        $display("full duplex test done");
    endtask
    task automatic t_mux();
        xfer(8'h8A, 1, 8'h11, 1'b0, 8);
        busPowerPresentIn = 1'b1;
        mux("bus power", 1'b1);
        busPowerPresentIn = 1'b0;
        mux("bus power", 1'b0);
        xfer(8'h8A, 1, 8'h12, 1'b0, 8);
        syncDetect = 1'b1;
        cyc(1);
        syncDetect = 1'b0;
        mux("traffic", 1'b1);
        jState = 1'b1;
        repeat (31) begin
            bitTick = 1'b1;
            cyc(1);
            bitTick = 1'b0;
            cyc(1);
        end
        mux("traffic 31", 1'b1);
        bitTick = 1'b1;
        cyc(1);
        bitTick = 1'b0;
        jState = 1'b0;
        mux("traffic 32", 1'b0);
        syncDetect = 1'b1;
        cyc(1);
        syncDetect = 1'b0;
        busReset = 1'b1;
        cyc(1);
        busReset = 1'b0;
        mux("traffic reset", 1'b0);
        xfer(8'h8A, 1, 8'h13, 1'b0, 8);
        sofPulse = 1'b1;
        cyc(1);
        sofPulse = 1'b0;
        mux("frame wave", 1'b1);
        cyc(18);
        mux("frame wave", 1'b0);
        xfer(8'h8A, 1, 8'h10, 1'b0, 8);
        mux("ready", 1'b1);
        $display("status mux test done");
    endtask
    task automatic t_irq();
        int w;
        xfer(8'h82, 1, 8'h01, 1'b0, 8);
        xfer(8'h8A, 1, 8'h14, 1'b0, 8);
        for (int k = 0; k < 3; k++) begin
            irqFlags = irqSeq[k];
            w = 0;
            while (irqOut !== 1'b1 && w < 8) begin
                cyc(1);
                w++;
            end
            w = 0;
            while (irqOut === 1'b1 && w < 20) begin
                cyc(1);
                w++;
            end
            chk("pulse", 8'd10, w[7:0]);
            cyc(10);
        end
        xfer(8'h8A, 1, 8'h1C, 1'b0, 8);
        cyc(3);
        chk("level pull", 8'h02, {6'h0, irqOe, irqOut});
        irqFlags = 8'h00;
        cyc(3);
        chk("level free", 8'h00, {7'h0, irqOe});
        xfer(8'h82, 1, 8'h00, 1'b0, 8);
        irqFlags = 8'h01;
        cyc(3);
        chk("irq disabled", 8'h00, {7'h0, irqOe});
        irqFlags = 8'h00;
        $display("interrupt test done");
    endtask
    task automatic t_ext();
        int w;
        xfer(8'h12, 3, 8'h40, 1'b0, 8);
        chk("ext addr", 8'h02, {3'h0, extWrAddr});
        chk("rd addr", 8'h02, {3'h0, extRdAddr});
        for (int k = 0; k < 3; k++) begin
            w = 0;
            while (extWrValid !== 1'b1 && w < 20) begin
                cyc(1);
                w++;
            end
            chk("ext data", 8'h40 + k[7:0], extWrData);
            extWrReady = 1'b1;
            cyc(1);
            extWrReady = 1'b0;
        end
        mux("ready", 1'b1);
        chk("ext drained", 8'h00, {7'h0, extWrValid});
        chk("no overrun", 8'h00, {7'h0, spiOverrun});
        $display("register write test done");
    endtask
    task automatic t_hard();
        hardResetInB = 1'b0;
        cyc(5);
        chk("chip reset", 8'h01, {7'h0, chipReset});
        hardResetInB = 1'b1;
        cyc(10);
        chk("gpout cleared", 8'h00, {4'h0, generalOutputs});
        xfer(8'hA0, 1, 8'hFF, 1'b0, 8);
        chk("mode kept", 8'hC0, rx);
        $display("chip reset test done");
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        cyc(2);
        rst_b = 1'b1;
        cyc(10);
        mux("ready", 1'b1);
        t_half();
        t_full();
        t_mux();
        t_irq();
        t_ext();
        t_hard();
        conclude();
    end
    // the sequence needs well under 100 us
    initial begin
        #500000;
        badCount++;
        $display("watchdog expired");
        conclude();
    end
endmodule
